// file: core/power_on_strap_capture.sv
// strap sampling, decode and axi4-lite register access
`timescale 1ns/1ps
// How it works
// - straps sampled a fixed time after system reset rises, inside the hold window.
// - deep sleep exit resamples into the raw register; of the decoded outputs only the reserved strap fault is taken over.
// - recovery strap 0 selects usb recovery, 1 selects secondary boot device.
// - reserved strap must sample 1; 0 raises a forbidden configuration flag.
// - debug chain 00 both serial, 01 main only, 10 auxiliary only, 11 reserved.
// - memory code bits 3:2 pick boot device set, bits 1:0 dram set.
// - boot device may come from fuse data instead of the strap pins.
// - recovery pin pull-up is enabled at reset; software can clear it through bit 0 of the control register.
// - debug reset pin low enables cpu debug access, high selects scan test.
module power_on_strap_capture (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          system_reset_input_low,
   input  wire strap_pkg::strap_type          strap_pins,
   input  wire logic                          factory_test_enable,
   input  wire logic                          debug_reset_pin,
   input  wire logic                          deep_sleep_exit,
   input  wire logic                          fuse_boot_select,
   input  wire logic [3:0]                    fuse_boot_code,
   output logic                               recovery_pullup_en,
   output logic                               config_valid,
   output logic                               boot_recovery_mode,
   output logic                               reserved_fault,
   output strap_pkg::chain_mode_type          debug_chain_mode,
   output logic [1:0]                         sec_boot_cfg_set,
   output logic [1:0]                         dram_cfg_set,
   output strap_pkg::boot_dev_type            boot_device,
   output logic                               test_mode_fault,
   output logic                               cpu_debug_enable,
   output logic                               scan_test_mode,
   input  wire logic                          awvalid,
   output logic                               awready,
   input  wire logic [strap_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                          wvalid,
   output logic                               wready,
   input  wire logic [strap_pkg::DATA_W-1:0]  wdata,
   input  wire logic [3:0]                    wstrb,
   output logic                               bvalid,
   input  wire logic                          bready,
   output logic [1:0]                         bresp,
   input  wire logic                          arvalid,
   output logic                               arready,
   input  wire logic [strap_pkg::ADDR_W-1:0]  araddr,
   output logic                               rvalid,
   input  wire logic                          rready,
   output logic [strap_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                         rresp
);
   localparam logic [strap_pkg::CNT_W-1:0] SAMPLE_LAST =
      strap_pkg::CNT_W'(strap_pkg::SAMPLE_CYCLES - 1);

   function automatic strap_pkg::boot_dev_type decode_boot(input logic [3:0] code);
      case (code)
         strap_pkg::CODE_SPI:   decode_boot = strap_pkg::BOOT_SPI_FLASH;
         strap_pkg::CODE_EMMC8: decode_boot = strap_pkg::BOOT_EMMC8_OFF;
         strap_pkg::CODE_FUSE:  decode_boot = strap_pkg::BOOT_USE_FUSE;
         default:               decode_boot = strap_pkg::BOOT_RESERVED;
      endcase
   endfunction

   logic [strap_pkg::SYNC_W-1:0] pins_meta_reg;
   logic [strap_pkg::SYNC_W-1:0] pins_sync_reg;
   logic                         sysrst_prev_reg;
   strap_pkg::strap_type         strap_sync;
   logic                         sysrst_sync;
   logic                         test_sync;
   logic                         dbg_sync;
   logic                         sysrst_rise;
   strap_pkg::cap_state_type     cap_state_reg;
   logic [strap_pkg::CNT_W-1:0]  cap_cnt_reg;
   logic                         capture_fire;
   strap_pkg::strap_type         raw_reg;
   strap_pkg::boot_dev_type      strap_dev;
   strap_pkg::boot_dev_type      boot_next;

   // two-flop synchronisers for every pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_meta_reg <= '0;
         pins_sync_reg <= '0;
      end else begin
         pins_meta_reg <= {debug_reset_pin, factory_test_enable, system_reset_input_low,
                           strap_pins};
         pins_sync_reg <= pins_meta_reg;
      end
   end

   assign strap_sync  = pins_sync_reg[11:0];
   assign sysrst_sync = pins_sync_reg[12];
   assign test_sync   = pins_sync_reg[13];
   assign dbg_sync    = pins_sync_reg[14];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sysrst_prev_reg <= 1'b0;
      end else begin
         sysrst_prev_reg <= sysrst_sync;
      end
   end

   assign sysrst_rise  = sysrst_sync && !sysrst_prev_reg;
   assign capture_fire = (cap_state_reg != strap_pkg::CAP_IDLE) && (cap_cnt_reg == SAMPLE_LAST);

   // sampling delay after reset rise or deep sleep exit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_state_reg <= strap_pkg::CAP_IDLE;
         cap_cnt_reg   <= '0;
      end else if (sysrst_rise) begin
         cap_state_reg <= strap_pkg::CAP_FULL;
         cap_cnt_reg   <= '0;
      end else if (deep_sleep_exit && cap_state_reg != strap_pkg::CAP_FULL) begin
         cap_state_reg <= strap_pkg::CAP_SLEEP;
         cap_cnt_reg   <= '0;
      end else begin
         case (cap_state_reg)
            strap_pkg::CAP_IDLE: begin
               cap_cnt_reg <= '0;
            end
            strap_pkg::CAP_FULL,
            strap_pkg::CAP_SLEEP: begin
               if (capture_fire) begin
                  cap_state_reg <= strap_pkg::CAP_IDLE;
                  cap_cnt_reg   <= '0;
               end else begin
                  cap_cnt_reg <= cap_cnt_reg + 1'b1;
               end
            end
            default: begin
               cap_state_reg <= strap_pkg::CAP_IDLE;
            end
         endcase
      end
   end

   // captured straps hold until the next capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_reg <= '0;
      end else if (capture_fire) begin
         raw_reg <= strap_sync;
      end
   end

   assign strap_dev = decode_boot(strap_sync.boot_code);
   assign boot_next = (fuse_boot_select || strap_dev == strap_pkg::BOOT_USE_FUSE) ?
                      decode_boot(fuse_boot_code) : strap_dev;

   // decoded boot configuration, full capture only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         config_valid       <= 1'b0;
         boot_recovery_mode <= 1'b0;
         debug_chain_mode   <= strap_pkg::CHAIN_SERIAL_BOTH;
         sec_boot_cfg_set   <= '0;
         dram_cfg_set       <= '0;
         boot_device        <= strap_pkg::BOOT_RESERVED;
      end else if (capture_fire && cap_state_reg == strap_pkg::CAP_FULL) begin
         config_valid       <= 1'b1;
         boot_recovery_mode <= !strap_sync.recovery_strap_pin;
         debug_chain_mode   <= strap_pkg::chain_mode_type'(
                               {strap_sync.debug_chain_select_hi,
                                strap_sync.debug_chain_select_lo});
         sec_boot_cfg_set   <= strap_sync.mem_code[3:2];
         dram_cfg_set       <= strap_sync.mem_code[1:0];
         boot_device        <= boot_next;
      end
   end

   // reserved strap checked on every capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reserved_fault <= 1'b0;
      end else if (capture_fire) begin
         reserved_fault <= !strap_sync.reserved_strap_pin;
      end
   end

   // live pin levels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         test_mode_fault  <= 1'b0;
         cpu_debug_enable <= 1'b1;
         scan_test_mode   <= 1'b0;
      end else begin
         test_mode_fault  <= test_sync;
         cpu_debug_enable <= !dbg_sync;
         scan_test_mode   <= dbg_sync;
      end
   end

   // axi4-lite write channel
   logic                        aw_hold_reg;
   logic                        w_hold_reg;
   logic [strap_pkg::ADDR_W-1:0] aw_addr_reg;
   logic [strap_pkg::DATA_W-1:0] w_data_reg;
   logic [3:0]                  w_strb_reg;
   logic                        do_write;
   logic                        addr_known;

   assign awready    = !aw_hold_reg && !bvalid;
   assign wready     = !w_hold_reg && !bvalid;
   assign do_write   = aw_hold_reg && w_hold_reg && !bvalid;
   assign addr_known = aw_addr_reg == strap_pkg::REG_RAW || aw_addr_reg == strap_pkg::REG_DECODE
                       || aw_addr_reg == strap_pkg::REG_CONTROL
                       || aw_addr_reg == strap_pkg::REG_STATUS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         bvalid      <= 1'b0;
         bresp       <= strap_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid      <= 1'b1;
            bresp       <= addr_known ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // control register: recovery pull-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         recovery_pullup_en <= strap_pkg::PULLUP_RESET;
      end else if (do_write && aw_addr_reg == strap_pkg::REG_CONTROL && w_strb_reg[0]) begin
         recovery_pullup_en <= w_data_reg[0];
      end
   end

   // axi4-lite read channel
   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= strap_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp  <= strap_pkg::RESP_OKAY;
         case (araddr)
            strap_pkg::REG_RAW:     rdata <= 32'(raw_reg);
            strap_pkg::REG_DECODE:  rdata <= 32'({boot_device, dram_cfg_set, sec_boot_cfg_set,
                                                  debug_chain_mode, boot_recovery_mode});
            strap_pkg::REG_CONTROL: rdata <= 32'(recovery_pullup_en);
            strap_pkg::REG_STATUS:  rdata <= 32'({cap_state_reg != strap_pkg::CAP_IDLE,
                                                  scan_test_mode, cpu_debug_enable,
                                                  test_mode_fault, reserved_fault,
                                                  config_valid});
            default: begin
               rdata <= '0;
               rresp <= strap_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_sample_moment: assert property (capture_fire |-> cap_cnt_reg == SAMPLE_LAST)
      else $error("capture not at sample count");
   a_sample_start: assert property (sysrst_rise |-> ##[1:300] capture_fire)
      else $error("no capture after reset rise");
   a_sleep_keep: assert property (capture_fire && cap_state_reg == strap_pkg::CAP_SLEEP
                                  |=> $stable(boot_device) && $stable(debug_chain_mode))
      else $error("deep sleep capture changed boot decode");
   a_recovery_sel: assert property (capture_fire && cap_state_reg == strap_pkg::CAP_FULL
                                    |=> boot_recovery_mode == !raw_reg.recovery_strap_pin)
      else $error("recovery decode wrong");
   a_reserved_flag: assert property (capture_fire |=> reserved_fault
                                     == !raw_reg.reserved_strap_pin)
      else $error("reserved fault wrong");
   a_mem_fields: assert property (capture_fire && cap_state_reg == strap_pkg::CAP_FULL
                                  |=> {sec_boot_cfg_set, dram_cfg_set} == raw_reg.mem_code)
      else $error("memory code fields wrong");
   a_hold_stable: assert property (!capture_fire |=> $stable(raw_reg))
      else $error("captured straps changed without capture");
   a_debug_sel: assert property (cpu_debug_enable != scan_test_mode)
      else $error("debug and scan both or neither");
   a_debug_follow: assert property ($past(dbg_sync) |-> scan_test_mode)
      else $error("scan mode not following pin");
   a_test_flag: assert property ($rose(test_sync) |=> test_mode_fault)
      else $error("test enable not reported");
   a_pullup_reset: assert property ($rose(aresetn) |-> recovery_pullup_en)
      else $error("pull-up off after reset");

   c_full_capture: cover property (capture_fire && cap_state_reg == strap_pkg::CAP_FULL);
   c_sleep_capture: cover property (capture_fire && cap_state_reg == strap_pkg::CAP_SLEEP);
   c_fuse_boot: cover property (capture_fire && fuse_boot_select);
   c_write_done: cover property (bvalid && bready);
endmodule

// file: core/strap_pkg.sv
// constants, types and register map for the strap capture block
package strap_pkg;
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          STRAP_HOLD_NS   = 12500;
   localparam int          STRAP_SAMPLE_NS = 5000;
   localparam int          SAMPLE_CYCLES   = STRAP_SAMPLE_NS / CLK_PERIOD_NS;
   localparam int          CNT_W           = 10;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam logic [7:0]  REG_RAW         = 8'h00;
   localparam logic [7:0]  REG_DECODE      = 8'h04;
   localparam logic [7:0]  REG_CONTROL     = 8'h08;
   localparam logic [7:0]  REG_STATUS      = 8'h0c;
   localparam logic        PULLUP_RESET    = 1'b1;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
   localparam logic [3:0]  CODE_SPI        = 4'h8;
   localparam logic [3:0]  CODE_EMMC8      = 4'hb;
   localparam logic [3:0]  CODE_FUSE       = 4'hf;
   localparam int          SYNC_W          = 15;

   typedef enum logic [1:0] {
      CHAIN_SERIAL_BOTH = 2'b00,
      CHAIN_MAIN_ONLY   = 2'b01,
      CHAIN_AUX_ONLY    = 2'b10,
      CHAIN_RESERVED    = 2'b11
   } chain_mode_type;

   typedef enum logic [1:0] {
      BOOT_SPI_FLASH = 2'b00,
      BOOT_EMMC8_OFF = 2'b01,
      BOOT_USE_FUSE  = 2'b10,
      BOOT_RESERVED  = 2'b11
   } boot_dev_type;

   typedef enum logic [1:0] {
      CAP_IDLE  = 2'b00,
      CAP_FULL  = 2'b01,
      CAP_SLEEP = 2'b10
   } cap_state_type;

   typedef struct packed {
      logic       recovery_strap_pin;
      logic       reserved_strap_pin;
      logic       debug_chain_select_hi;
      logic       debug_chain_select_lo;
      logic [3:0] mem_code;
      logic [3:0] boot_code;
   } strap_type;
endpackage

// file: sim/strap_board.sv
// board strap resistors and debug connector model
`timescale 1ns/1ps
module strap_board #(
   parameter int HOLD_CYCLES = 625
) (
   input  wire logic                 aclk,
   input  wire logic                 power_good,
   input  wire strap_pkg::strap_type board_cfg,
   input  wire logic                 scan_select,
   input  wire logic                 test_enable,
   output strap_pkg::strap_type      strap_pins,
   output logic                      system_reset_input_low,
   output logic                      factory_test_enable,
   output logic                      debug_reset_pin
);
   int hold_cnt = 0;
   assign system_reset_input_low = power_good;
   assign factory_test_enable    = test_enable;
   assign debug_reset_pin        = scan_select;
   // hold window counted from reset pin rise
   always @(posedge aclk) begin
      if (!power_good) begin
         hold_cnt <= HOLD_CYCLES;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end
   end
   // resistors only change while reset is low or after the window
   always @(posedge aclk) begin
      if (!power_good || hold_cnt == 0) begin
         strap_pins <= board_cfg;
      end
   end
endmodule

// file: sim/tb_top.sv
// self-checking bench for the strap capture block
`timescale 1ns/1ps
module tb_top;
   logic                      aclk = 1'b0, aresetn = 1'b0, power_good = 1'b0;
   logic                      scan_select = 1'b0, test_enable = 1'b0;
   logic                      deep_sleep_exit = 1'b0, fuse_boot_select = 1'b0;
   logic [3:0]                fuse_boot_code = 4'h8, wstrb = 4'h0;
   strap_pkg::strap_type      board_cfg = 12'hc00;
   strap_pkg::strap_type      strap_pins;
   logic                      system_reset_input_low, factory_test_enable, debug_reset_pin;
   logic                      awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                      arvalid = 1'b0, rready = 1'b0;
   logic [7:0]                awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]               wdata = 32'h0, rdata;
   logic                      awready, wready, bvalid, arready, rvalid;
   logic [1:0]                bresp, rresp, sec_boot_cfg_set, dram_cfg_set;
   logic                      recovery_pullup_en, config_valid, boot_recovery_mode;
   logic                      reserved_fault, test_mode_fault, cpu_debug_enable, scan_test_mode;
   strap_pkg::chain_mode_type debug_chain_mode;
   strap_pkg::boot_dev_type   boot_device;
   int                        miscompares = 0;
   int                        checks = 0;

   always #10 aclk = ~aclk;

   strap_board board_u (
      .aclk, .power_good, .board_cfg, .scan_select, .test_enable, .strap_pins,
      .system_reset_input_low, .factory_test_enable, .debug_reset_pin
   );
   power_on_strap_capture dut_u (
      .aclk, .aresetn, .system_reset_input_low, .strap_pins, .factory_test_enable,
      .debug_reset_pin, .deep_sleep_exit, .fuse_boot_select, .fuse_boot_code,
      .recovery_pullup_en, .config_valid, .boot_recovery_mode, .reserved_fault,
      .debug_chain_mode, .sec_boot_cfg_set, .dram_cfg_set, .boot_device, .test_mode_fault,
      .cpu_debug_enable, .scan_test_mode, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
      .rready, .rdata, .rresp
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // fused selection decodes the fuse code in place of the strap code
   function automatic logic [1:0] dev_of(input logic [3:0] c, input logic f, input logic [3:0] fc);
      logic [3:0] k;
      k = (f || c == strap_pkg::CODE_FUSE) ? fc : c;
      if (k == strap_pkg::CODE_FUSE) return 2'b10;
      if (k == strap_pkg::CODE_SPI) return 2'b00;
      if (k == strap_pkg::CODE_EMMC8) return 2'b01;
      return 2'b11;
   endfunction

   task automatic power_cycle(input strap_pkg::strap_type cfg);
      @(posedge aclk);
      power_good <= 1'b0;
      board_cfg <= cfg;
      repeat (5) @(posedge aclk);
      power_good <= 1'b1;
      repeat (270) @(posedge aclk);
   endtask

   task automatic check_capture(input strap_pkg::strap_type c);
      logic [31:0] d;
      logic [1:0]  r;
      logic [1:0]  dev;
      dev = dev_of(c.boot_code, fuse_boot_select, fuse_boot_code);
      chk(32'(config_valid), 32'h1);
      chk(32'(boot_recovery_mode), 32'(!c.recovery_strap_pin));
      chk(32'(reserved_fault), 32'(!c.reserved_strap_pin));
      chk(32'(debug_chain_mode), 32'(c[9:8]));
      chk(32'({sec_boot_cfg_set, dram_cfg_set}), 32'(c.mem_code));
      chk(32'(boot_device), 32'(dev));
      axi_read(strap_pkg::REG_RAW, d, r);
      chk(d, 32'(c));
      axi_read(strap_pkg::REG_DECODE, d, r);
      chk(d & 32'h1fe, {23'h0, dev, c.mem_code[1:0], c.mem_code[3:2], c[9:8], 1'b0});
   endtask

   task automatic test_reset;
      chk(32'({recovery_pullup_en, config_valid}), 32'h2);
      chk(32'(boot_device), 32'h3);
      $display("test_reset done");
   endtask

   task automatic test_table;
      strap_pkg::strap_type tab [4];
      tab = '{12'h468, 12'hd9b, 12'hacf, 12'hf35};
      foreach (tab[i]) begin
         power_cycle(tab[i]);
         check_capture(tab[i]);
      end
      fuse_boot_select <= 1'b1;
      fuse_boot_code <= 4'hb;
      power_cycle(12'hc28);
      check_capture(12'hc28);
      fuse_boot_select <= 1'b0;
      $display("test_table done");
   endtask

   task automatic sleep_exit;
      @(posedge aclk);
      deep_sleep_exit <= 1'b1;
      @(posedge aclk);
      deep_sleep_exit <= 1'b0;
      repeat (270) @(posedge aclk);
   endtask

   task automatic test_sleep;
      logic [31:0] d;
      logic [1:0]  r;
      power_cycle(12'hc68);
      board_cfg <= 12'hab5;
      repeat (400) @(posedge aclk);
      chk(32'({debug_chain_mode, reserved_fault}), 32'h0);
      sleep_exit;
      chk(32'(reserved_fault), 32'h1);
      chk(32'({debug_chain_mode, boot_device, boot_recovery_mode}), 32'h0);
      axi_read(strap_pkg::REG_RAW, d, r);
      chk(d, 32'h0000_0ab5);
      board_cfg <= 12'hc68;
      sleep_exit;
      chk(32'(reserved_fault), 32'h0);
      $display("test_sleep done");
   endtask

   task automatic test_debug;
      logic [31:0] d;
      logic [1:0]  r;
      scan_select <= 1'b1;
      test_enable <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(32'({scan_test_mode, cpu_debug_enable, test_mode_fault}), 32'h5);
      axi_read(strap_pkg::REG_STATUS, d, r);
      chk(d & 32'h1c, 32'h14);
      scan_select <= 1'b0;
      test_enable <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(32'({scan_test_mode, cpu_debug_enable, test_mode_fault}), 32'h2);
      $display("test_debug done");
   endtask

   task automatic test_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(strap_pkg::REG_CONTROL, d, r);
      chk(d & 32'h1, 32'h1);
      axi_write(strap_pkg::REG_CONTROL, 32'h0, r);
      chk(32'(r), 32'(strap_pkg::RESP_OKAY));
      repeat (2) @(posedge aclk);
      chk(32'(recovery_pullup_en), 32'h0);
      axi_write(strap_pkg::REG_CONTROL, 32'h1, r);
      axi_write(strap_pkg::REG_RAW, 32'hfff, r);
      chk(32'(r), 32'(strap_pkg::RESP_OKAY));
      axi_read(strap_pkg::REG_RAW, d, r);
      chk(d, 32'h0000_0c68);
      axi_read(8'h10, d, r);
      chk(32'(r), 32'(strap_pkg::RESP_SLVERR));
      axi_write(8'h14, 32'h1, r);
      chk(32'(r), 32'(strap_pkg::RESP_SLVERR));
      chk(32'(recovery_pullup_en), 32'h1);
      $display("test_regs done");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (10000) @(posedge aclk);
      miscompares++;
      tally_and_finish;
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      test_reset;
      test_table;
      test_sleep;
      test_debug;
      test_regs;
      tally_and_finish;
   end
endmodule
